// [rtl/host_bus_arbiter.sv]
// Behaviour
// - Modes 1 and 2: low bus_grant_n means the bus is granted to us.
// - Modes 3 and 4: low hold_ack_n means the previous master released the bus.
// - Mode 1: grant_acknowledge_n is three-state, driven low by the current owner.
// - Modes 2-4: bus_busy_n is wire-OR, three-state, driven low by the current owner.
// - Back-off with setup met: give up the bus after the current cycle.
// - After back-off drops, re-arbitrate and resume the interrupted cycle sequence.
// - Back-off is sampled at every start cycle we would begin as master.
// - Late back-off: release within two clocks; pending start becomes release.
// - Back-off during arbitration: finish arbitration, leave at first start cycle.
// - All host-side activity is synchronous to the host bus clock.
// - Reset input forces a complete reset regardless of bus mode.
// - Modes 3 and 4 request via hold request; modes 1 and 2 via bus request.
`include "arb_map.svh"
`timescale 1ns/1ps
`default_nettype none

module host_bus_arbiter (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Mode selection
	input  wire logic [2:0] bus_mode_select,
	// Arbitration inputs
	input  wire logic       bus_grant_n,
	input  wire logic       hold_ack_n,
	input  wire logic       back_off_n,
	// Request outputs
	output logic            bus_request_n,
	output logic            hold_request_n,
	// Grant acknowledge pin, mode 1
	input  wire logic       grant_acknowledge_n_in,
	output logic            grant_acknowledge_n_out,
	output logic            grant_acknowledge_n_oe,
	// Bus busy pin, modes 2 to 4
	input  wire logic       bus_busy_n_in,
	output logic            bus_busy_n_out,
	output logic            bus_busy_n_oe,
	// Core side
	input  wire logic       xfer_req,
	input  wire logic       cycle_last,
	input  wire logic       cycle_done,
	output logic            start_cycle,
	output logic            is_master,
	output logic            backed_off
);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode

	function automatic arb_pkg::busy_var_e mode_var(input logic [2:0] m);
		case (m)
			`MODE_1: mode_var = arb_pkg::VAR_GACK;
			`MODE_2,
			`MODE_3,
			`MODE_4: mode_var = arb_pkg::VAR_BUSY;
			default: mode_var = arb_pkg::VAR_NONE;
		endcase
	endfunction

	function automatic logic hold_style(input logic [2:0] m);
		hold_style = (m == `MODE_3) || (m == `MODE_4);
	endfunction

	arb_pkg::busy_var_e var_w;
	logic               granted_w;
	logic               busy_line_w;
	logic               back_off_n_w;
	logic               hold_w;

	always_comb begin
		var_w = mode_var(bus_mode_select);
		hold_w = hold_style(bus_mode_select);
		// Grant meaning depends on mode
		granted_w = hold_style(bus_mode_select) ? ~hold_ack_n : ~bus_grant_n;
		busy_line_w = (var_w == arb_pkg::VAR_GACK) ? ~grant_acknowledge_n_in : ~bus_busy_n_in;
		back_off_n_w = ~back_off_n;
	end

	////////////////////////////////////////////////////////////////////////////
	// Arbitration state

	arb_pkg::arb_state_e state_q, state_d;
	logic                req_q, req_d;
	logic                own_q, own_d;
	logic                start_q, start_d;
	logic                boffd_q, boffd_d;
	logic                resume_q, resume_d;

	always_comb begin
		state_d  = state_q;
		req_d    = req_q;
		own_d    = 1'b0;
		start_d  = 1'b0;
		boffd_d  = boffd_q;
		resume_d = resume_q;
		case (state_q)
			arb_pkg::ST_IDLE: begin
				// Re-arbitrate once back-off drops
				if ((xfer_req || resume_q) && !back_off_n_w && var_w != arb_pkg::VAR_NONE) begin
					state_d = arb_pkg::ST_REQ;
					req_d   = 1'b1;
				end
			end
			arb_pkg::ST_REQ: begin
				// Arbitration completes even under back-off
				if (granted_w && !busy_line_w) begin
					state_d = arb_pkg::ST_OWN;
					req_d   = 1'b0;
					own_d   = 1'b1;
				end
			end
			arb_pkg::ST_OWN: begin
				own_d = 1'b1;
				// Back-off checked at each start cycle
				if (back_off_n_w) begin
					state_d  = arb_pkg::ST_RELEASE;
					own_d    = 1'b0;
					resume_d = 1'b1;
					boffd_d  = 1'b1;
				end else if (xfer_req || resume_q) begin
					state_d  = arb_pkg::ST_CYCLE;
					start_d  = 1'b1;
					resume_d = 1'b0;
				end else begin
					state_d = arb_pkg::ST_RELEASE;
					own_d   = 1'b0;
				end
			end
			arb_pkg::ST_CYCLE: begin
				own_d = 1'b1;
				if (cycle_done) begin
					if (back_off_n_w) begin
						state_d  = arb_pkg::ST_RELEASE;
						own_d    = 1'b0;
						resume_d = !cycle_last;
						boffd_d  = 1'b1;
					end else if (cycle_last) begin
						state_d = arb_pkg::ST_RELEASE;
						own_d   = 1'b0;
					end else begin
						state_d = arb_pkg::ST_OWN;
					end
				end
			end
			arb_pkg::ST_RELEASE: begin
				state_d = boffd_q ? arb_pkg::ST_BACKOFF : arb_pkg::ST_IDLE;
			end
			arb_pkg::ST_BACKOFF: begin
				// Held off until back-off deasserts
				if (!back_off_n_w) begin
					state_d = arb_pkg::ST_IDLE;
					boffd_d = 1'b0;
				end
			end
			default: begin
				state_d = arb_pkg::ST_IDLE;
				req_d   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q  <= arb_pkg::ST_IDLE;
			req_q    <= 1'b0;
			own_q    <= 1'b0;
			start_q  <= 1'b0;
			boffd_q  <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			req_q    <= req_d;
			own_q    <= own_d;
			start_q  <= start_d;
			boffd_q  <= boffd_d;
			resume_q <= resume_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin outputs, all registered

	logic breq_n_q, breq_n_d;
	logic hreq_n_q, hreq_n_d;
	logic gack_oe_q, gack_oe_d;
	logic busy_oe_q, busy_oe_d;
	logic gack_out_q, gack_out_d;
	logic busy_out_q, busy_out_d;

	always_comb begin
		breq_n_d   = ~(req_d && !hold_w);
		hreq_n_d   = ~(req_d && hold_w);
		gack_oe_d  = own_d && (var_w == arb_pkg::VAR_GACK);
		busy_oe_d  = own_d && (var_w == arb_pkg::VAR_BUSY);
		// Driven level is low whenever we own the pin
		gack_out_d = ~gack_oe_d;
		busy_out_d = ~busy_oe_d;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			breq_n_q  <= 1'b1;
			hreq_n_q  <= 1'b1;
			gack_oe_q <= 1'b0;
			busy_oe_q <= 1'b0;
			gack_out_q <= 1'b1;
			busy_out_q <= 1'b1;
		end else begin
			breq_n_q  <= breq_n_d;
			hreq_n_q  <= hreq_n_d;
			gack_oe_q <= gack_oe_d;
			busy_oe_q <= busy_oe_d;
			gack_out_q <= gack_out_d;
			busy_out_q <= busy_out_d;
		end
	end

	assign bus_request_n           = breq_n_q;
	assign hold_request_n          = hreq_n_q;
	assign grant_acknowledge_n_out = gack_out_q;
	assign grant_acknowledge_n_oe  = gack_oe_q;
	assign bus_busy_n_out          = busy_out_q;
	assign bus_busy_n_oe           = busy_oe_q;
	assign start_cycle             = start_q;
	assign is_master               = own_q;
	assign backed_off              = boffd_q;

endmodule

`default_nettype wire

// [rtl/arb_map.svh]
`ifndef ARB_MAP_SVH
`define ARB_MAP_SVH

// Bus mode select encodings
`define MODE_1          3'h1
`define MODE_2          3'h2
`define MODE_3          3'h3
`define MODE_4          3'h4

// Worst case release time after a late back-off, in clocks
`define LATE_RELEASE_CLKS 2

`endif

// [rtl/arb_pkg.sv]
package arb_pkg;

	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_REQ     = 6'h02,
		ST_OWN     = 6'h04,
		ST_CYCLE   = 6'h08,
		ST_RELEASE = 6'h10,
		ST_BACKOFF = 6'h20
	} arb_state_e;

	typedef enum logic [1:0] {
		VAR_GACK = 2'h0,
		VAR_BUSY = 2'h1,
		VAR_NONE = 2'h2
	} busy_var_e;

endpackage

// [dv/host_bus_arbiter_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module arb_checker (
	input wire logic       mclk, rst,
	input wire logic [2:0] bus_mode_select,
	input wire logic       bus_grant_n, hold_ack_n, back_off_n, bus_request_n, hold_request_n,
	input wire logic       grant_acknowledge_n_out, grant_acknowledge_n_oe, bus_busy_n_out, bus_busy_n_oe,
	input wire logic       cycle_last, cycle_done, start_cycle, is_master, backed_off
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence rel_s;
		!is_master && backed_off;
	endsequence
	AST_REQ: assert property ($fell(bus_request_n) |-> $past(back_off_n))
		else $error("request raised under back-off");
	AST_RQM: assert property (!bus_request_n |-> bus_mode_select inside {3'h1, 3'h2})
		else $error("bus request in wrong mode");
	AST_HQM: assert property (!hold_request_n |-> bus_mode_select inside {3'h3, 3'h4})
		else $error("hold request in wrong mode");
	AST_OWN: assert property ($rose(is_master) && bus_mode_select < 3'h3 |-> $past(bus_grant_n) == 1'b0)
		else $error("ownership without grant");
	AST_HLD: assert property ($rose(is_master) && bus_mode_select > 3'h2 |-> $past(hold_ack_n) == 1'b0)
		else $error("ownership without hold ack");
	AST_GACK: assert property (grant_acknowledge_n_oe |-> bus_mode_select == 3'h1 && is_master && !grant_acknowledge_n_out)
		else $error("grant ack driven wrongly");
	AST_BUSY: assert property (bus_busy_n_oe |-> bus_mode_select != 3'h1 && is_master && !bus_busy_n_out)
		else $error("bus busy driven wrongly");
	AST_START: assert property (start_cycle |-> is_master && $past(back_off_n))
		else $error("start under back-off");
	AST_LATE: assert property ($rose(is_master) && !back_off_n |-> ##[1:2] rel_s)
		else $error("late back-off release slow");
	AST_DONE: assert property (cycle_done && is_master && !back_off_n |=> rel_s)
		else $error("no release after cycle");
	AST_LAST: assert property (cycle_done && cycle_last && back_off_n |=> !is_master)
		else $error("bus kept after last cycle");
endmodule
`default_nettype wire

// [dv/host_arbiter_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_arbiter_model (
	input wire logic       mclk, rst,
	input wire logic [2:0] mode,
	input wire logic       bus_request_n, hold_request_n,
	input wire logic [3:0] lat,
	output logic           bus_grant_n, hold_ack_n
);
	logic [3:0] n;
	logic       g;
	wire logic  rq = mode < 3'h3 ? !bus_request_n : !hold_request_n;
	// Grant after lat cycles of request, dropped with it
	always @(negedge mclk or posedge rst) begin
		if (rst) begin
			n <= 4'h0;
			g <= 1'b0;
		end else begin
			n <= rq ? n + 4'h1 : 4'h0;
			g <= rq && (g || n >= lat);
		end
	end
	assign bus_grant_n = !(g && mode < 3'h3);
	assign hold_ack_n  = !(g && mode > 3'h2);
endmodule
`default_nettype wire

// [dv/host_bus_mastership_arbitration_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module host_bus_mastership_arbitration_tb;
	logic       mclk = 0, rst = 1, other = 0, xr = 0, cl = 0, cd = 0, bo = 1;
	logic [2:0] md  = 3'h1;
	logic [3:0] lat = 4'h1;
	wire logic  bg, ha, br, hr, go, ge, bu, be, st, im, bk, gi, bi;
	int         fail_count = 0, checks = 0;
	// Pulled-up shared pins
	assign gi = !(ge && !go) && !other;
	assign bi = !(be && !bu) && !other;
	host_bus_arbiter host_bus_arbiter_i (.mclk, .rst, .bus_mode_select(md), .bus_grant_n(bg), .hold_ack_n(ha),
		.back_off_n(bo), .bus_request_n(br), .hold_request_n(hr), .grant_acknowledge_n_in(gi),
		.grant_acknowledge_n_out(go), .grant_acknowledge_n_oe(ge), .bus_busy_n_in(bi), .bus_busy_n_out(bu),
		.bus_busy_n_oe(be), .xfer_req(xr), .cycle_last(cl), .cycle_done(cd), .start_cycle(st), .is_master(im),
		.backed_off(bk));
	host_arbiter_model host_arbiter_model_i (.mclk, .rst, .mode(md), .bus_request_n(br), .hold_request_n(hr),
		.lat, .bus_grant_n(bg), .hold_ack_n(ha));
	initial forever #10 mclk = ~mclk;
	task chk(string nm, logic s, logic e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %b seen %b", nm, e, s);
		end
	endtask
	task give_verdict;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task wt(bit s, logic v);
		int n;
		for (n = 0; n < 20 && (s ? st : im) !== v; n++) @(negedge mclk);
		if (n == 20) begin
			fail_count++;
			give_verdict;
		end
	endtask
	task own(logic [2:0] m);
		md = m;
		xr = 1;
		@(negedge mclk);
		chk("req", m < 3'h3 ? br : hr, 1'b0);
		wt(0, 1);
		chk("oe", m == 3'h1 ? ge : be, 1'b1);
	endtask
	task fin;
		wt(1, 1);
		xr = 0;
		cd = 1;
		cl = 1;
		@(negedge mclk);
		cd = 0;
		cl = 0;
		@(negedge mclk);
		chk("rel", be | ge, 1'b0);
	endtask
	task s_cyc;
		own(3'h3);
		wt(1, 1);
		bo = 0;
		cd = 1;
		@(negedge mclk);
		cd = 0;
		@(negedge mclk);
		chk("back_off_n", bk & !im, 1'b1);
		repeat (3) @(negedge mclk);
		chk("hold", hr, 1'b1);
		bo = 1;
		wt(0, 1);
		fin;
	endtask
	initial begin
		repeat (16) @(negedge mclk);
		rst = 0;
		for (int m = 1; m < 5; m++) begin
			lat = 4'(m);
			own(3'(m));
			fin;
		end
		md = 3'h2;
		xr = 1;
		@(negedge mclk);
		bo = 0;
		wt(0, 1);
		xr = 0;
		repeat (2) @(negedge mclk);
		chk("arb", bk & !im, 1'b1);
		bo = 1;
		wt(0, 1);
		fin;
		s_cyc;
		md = 3'h4;
		other = 1;
		xr = 1;
		repeat (6) @(negedge mclk);
		chk("blk", im, 1'b0);
		other = 0;
		wt(0, 1);
		fin;
		md = 3'h0;
		xr = 1;
		repeat (4) @(negedge mclk);
		chk("bad", br & hr, 1'b1);
		xr = 0;
		own(3'h1);
		rst = 1;
		@(negedge mclk);
		chk("rst", im | ge, 1'b0);
		rst = 0;
		give_verdict;
	end
endmodule
bind host_bus_arbiter arb_checker arb_checker_i (.mclk, .rst, .bus_mode_select, .bus_grant_n, .hold_ack_n,
	.back_off_n, .bus_request_n, .hold_request_n, .grant_acknowledge_n_out, .grant_acknowledge_n_oe,
	.bus_busy_n_out, .bus_busy_n_oe, .cycle_last, .cycle_done, .start_cycle, .is_master, .backed_off);
`default_nettype wire
